// ==== core/gts_pkg.sv ====
// Constants, register map and control layout of the general timer set.
// Assumes a 32-bit APB master and byte addresses on paddr.
package gts_pkg;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] OFF_A_CTRL = 8'h00;
  localparam logic [7:0] OFF_A_CNT = 8'h04;
  localparam logic [7:0] OFF_A_PER = 8'h08;
  localparam logic [7:0] OFF_B_CTRL = 8'h0C;
  localparam logic [7:0] OFF_B_CNT = 8'h10;
  localparam logic [7:0] OFF_B_PER = 8'h14;
  localparam logic [7:0] OFF_C_CTRL = 8'h18;
  localparam logic [7:0] OFF_C_CNT = 8'h1C;
  localparam logic [7:0] OFF_C_PER = 8'h20;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h24;
  localparam logic [7:0] OFF_IRQ_EN = 8'h28;

  // ****************************************************************
  // Reset values and implemented-bit masks.
  // ****************************************************************
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'hFFFF;
  localparam logic [15:0] MASK_A_CTRL = 16'hA076;
  localparam logic [15:0] MASK_B_CTRL = 16'hA07A;
  localparam logic [15:0] MASK_C_CTRL = 16'hA072;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ****************************************************************
  // Prescaler terminal counts.
  // ****************************************************************
  localparam logic [7:0] PS_TC_1 = 8'h00;
  localparam logic [7:0] PS_TC_8 = 8'h07;
  localparam logic [7:0] PS_TC_64 = 8'h3F;
  localparam logic [7:0] PS_TC_256 = 8'hFF;

  // ****************************************************************
  // Control register layout, bit 15 down to bit 0.
  // ****************************************************************
  typedef struct packed {
    logic count_run_enable;
    logic rsv14;
    logic idle_halt_select;
    logic [5:0] rsv12_7;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic pair_wide_mode;
    logic ext_clock_sync_select;
    logic clock_source_select;
    logic rsv0;
  } gts_ctrl_t;

endpackage

// ==== core/gts_timer_set.sv ====
// General timer set: timer A plus the pairable timers B and C on APB.
// Assumes idle_mode and sleep_mode come from logic on sys_clk, and that
// the external clock pins are asynchronous to sys_clk.
//
// Functional notes
// - Timer A is 16 bits: timer, synchronous or asynchronous counter.
// - Timer A flags on period match or gated-mode gate falling edge.
// - Control bit 15 starts the timer when one, stops it when zero.
// - Idle-halt bit one stops timer A in Idle; zero keeps it running.
// - Gate accumulation works only with the internal clock selected.
// - Prescale field 11, 10, 01, 00 divides by 256, 64, 8, 1.
// - Sync bit picks synchronised external clock; ignored when internal.
// - Clock-source bit one counts external pin rising edges, else internal.
// - Unimplemented timer A control bits read as zero.
// - Timers B and C alone never count asynchronously.
// - Paired B and C form one 32-bit timer or synchronous counter.
// - In 32-bit mode B count is low half, C count high half.
// - In 32-bit mode C control is ignored; B control and pin rule.
// - In 32-bit mode the match raises timer C's flag, not B's.
// - 32-bit period compare uses C period high, B period low.
// - Only the paired 32-bit timer drives the ADC trigger.
// - Timer B and C counts are offered as capture/compare time bases.
// - Timers keep running in Idle unless idle-halted; in Sleep only timer A on the unsynchronised external clock counts.
// - Timer B control bit 3 joins B and C into one 32-bit timer.
// - B and C control share the on, idle, gate, prescale, source bits.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module gts_timer_set #(
  parameter int ADDR_W = 8
) (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Device power state.
  input wire logic idle_mode,
  input wire logic sleep_mode,
  // External clock and gate pins.
  input wire logic timer_a_ext_clock_pin,
  input wire logic timer_b_ext_clock_pin,
  input wire logic timer_c_ext_clock_pin,
  // APB slave.
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt requests, trigger and time bases.
  output logic timer_a_irq,
  output logic timer_b_irq,
  output logic timer_c_irq,
  output logic adc_trigger,
  output logic [15:0] time_base_b,
  output logic [15:0] time_base_c
);

  // ****************************************************************
  // Storage.
  // ****************************************************************
  logic [15:0] ctrl_q [3];
  logic [15:0] cnt_q [3];
  logic [15:0] per_q [3];
  logic [2:0] flag_q;
  logic [2:0] ien_q;
  logic [2:0] irq_q;
  logic adc_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  gts_pkg::gts_ctrl_t cfg [3];
  logic [2:0] tick;
  logic [2:0] gate_fall;
  logic [2:0] gate_lvl;
  logic [2:0] ev;
  logic [2:0] match16;
  logic match32;
  logic wide;
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd_mux;
  logic [15:0] c_next;

  // Merges a 16-bit write under the two low byte strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old[15:8],
               strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ****************************************************************
  // APB decode.
  // ****************************************************************
  assign setup = psel && !penable;
  assign wr = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wide = cfg[1].pair_wide_mode;

  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr[7:0])
      gts_pkg::OFF_A_CTRL: rd_mux[15:0] = ctrl_q[0];
      gts_pkg::OFF_A_CNT: rd_mux[15:0] = cnt_q[0];
      gts_pkg::OFF_A_PER: rd_mux[15:0] = per_q[0];
      gts_pkg::OFF_B_CTRL: rd_mux[15:0] = ctrl_q[1];
      gts_pkg::OFF_B_CNT: rd_mux[15:0] = cnt_q[1];
      gts_pkg::OFF_B_PER: rd_mux[15:0] = per_q[1];
      gts_pkg::OFF_C_CTRL: rd_mux[15:0] = ctrl_q[2];
      gts_pkg::OFF_C_CNT: rd_mux[15:0] = cnt_q[2];
      gts_pkg::OFF_C_PER: rd_mux[15:0] = per_q[2];
      gts_pkg::OFF_IRQ_FLAG: rd_mux[2:0] = flag_q;
      gts_pkg::OFF_IRQ_EN: rd_mux[2:0] = ien_q;
      default: hit = 1'b0;
    endcase
    if ((paddr >> 8) != '0) begin
      hit = 1'b0;
      rd_mux = 32'h0000_0000;
    end
  end

  // Answers every transfer with one access cycle; data is caught at setup.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q <= setup;
      pslverr_q <= setup && !hit;
      prdata_q <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Control, period and enable registers.
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        ctrl_q[i] <= gts_pkg::CTRL_RESET;
        per_q[i] <= gts_pkg::PER_RESET;
      end
      ien_q <= gts_pkg::IRQ_RESET;
    end else if (clk_en && wr) begin
      unique case (paddr[7:0])
        gts_pkg::OFF_A_CTRL:
          ctrl_q[0] <= merge16(ctrl_q[0], pwdata[15:0], pstrb[1:0])
                       & gts_pkg::MASK_A_CTRL;
        gts_pkg::OFF_B_CTRL:
          ctrl_q[1] <= merge16(ctrl_q[1], pwdata[15:0], pstrb[1:0])
                       & gts_pkg::MASK_B_CTRL;
        gts_pkg::OFF_C_CTRL:
          ctrl_q[2] <= merge16(ctrl_q[2], pwdata[15:0], pstrb[1:0])
                       & gts_pkg::MASK_C_CTRL;
        gts_pkg::OFF_A_PER:
          per_q[0] <= merge16(per_q[0], pwdata[15:0], pstrb[1:0]);
        gts_pkg::OFF_B_PER:
          per_q[1] <= merge16(per_q[1], pwdata[15:0], pstrb[1:0]);
        gts_pkg::OFF_C_PER:
          per_q[2] <= merge16(per_q[2], pwdata[15:0], pstrb[1:0]);
        gts_pkg::OFF_IRQ_EN:
          if (pstrb[0]) begin
            ien_q <= pwdata[2:0];
          end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Per-timer pin synchroniser, clock selection and prescaler.
  // ****************************************************************
  logic [2:0] pin_in;
  assign pin_in = {timer_c_ext_clock_pin, timer_b_ext_clock_pin,
                   timer_a_ext_clock_pin};

  for (genvar g = 0; g < 3; g++) begin : g_chan
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic s4_q;
    logic [7:0] ps_q;
    logic [7:0] tc;
    logic run;
    logic gated;
    logic ext_rise;
    logic may_sleep;
    logic raw;

    assign cfg[g] = gts_pkg::gts_ctrl_t'(ctrl_q[g]);
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        s4_q <= 1'b0;
      end else if (clk_en) begin
        s1_q <= pin_in[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
        s4_q <= s3_q;
      end
    end

    // Only timer A may take the shorter, unsynchronised edge path.
    if (g == 0) begin : g_async
      assign ext_rise = cfg[g].ext_clock_sync_select ? (s3_q && !s4_q)
                                                     : (s2_q && !s3_q);
      assign may_sleep = !cfg[g].ext_clock_sync_select;
    end else begin : g_sync
      assign ext_rise = s3_q && !s4_q;
      assign may_sleep = 1'b0;
    end

    assign gate_lvl[g] = s2_q;
    assign run = cfg[g].count_run_enable
                 && !(idle_mode && cfg[g].idle_halt_select);
    assign gated = !cfg[g].clock_source_select
                   && cfg[g].gate_accumulate_enable;
    assign raw = cfg[g].clock_source_select
                 ? (ext_rise && (may_sleep || !sleep_mode))
                 : (!sleep_mode && (!gated || s2_q));

    always_comb begin
      unique case (cfg[g].prescale_select)
        2'b00: tc = gts_pkg::PS_TC_1;
        2'b01: tc = gts_pkg::PS_TC_8;
        2'b10: tc = gts_pkg::PS_TC_64;
        2'b11: tc = gts_pkg::PS_TC_256;
      endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ps_q <= 8'h00;
      end else if (clk_en) begin
        if (!run) begin
          ps_q <= 8'h00;
        end else if (raw) begin
          ps_q <= (ps_q >= tc) ? 8'h00 : ps_q + 8'h01;
        end
      end
    end

    assign tick[g] = clk_en && run && raw && (ps_q >= tc);
    assign gate_fall[g] = clk_en && run && gated && s3_q && !s2_q;
    assign match16[g] = (cnt_q[g] == per_q[g]);
  end

  // ****************************************************************
  // Counters.
  // ****************************************************************
  assign match32 = ({cnt_q[2], cnt_q[1]} == {per_q[2], per_q[1]});
  assign c_next = (cnt_q[1] == 16'hFFFF) ? cnt_q[2] + 16'h0001 : cnt_q[2];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        cnt_q[i] <= gts_pkg::CNT_RESET;
      end
    end else if (clk_en) begin
      if (wr && paddr[7:0] == gts_pkg::OFF_A_CNT) begin
        cnt_q[0] <= merge16(cnt_q[0], pwdata[15:0], pstrb[1:0]);
      end else if (tick[0]) begin
        cnt_q[0] <= match16[0] ? 16'h0000 : cnt_q[0] + 16'h0001;
      end
      if (wr && paddr[7:0] == gts_pkg::OFF_B_CNT) begin
        cnt_q[1] <= merge16(cnt_q[1], pwdata[15:0], pstrb[1:0]);
      end else if (tick[1]) begin
        if (wide) begin
          cnt_q[1] <= match32 ? 16'h0000 : cnt_q[1] + 16'h0001;
        end else begin
          cnt_q[1] <= match16[1] ? 16'h0000 : cnt_q[1] + 16'h0001;
        end
      end
      if (wr && paddr[7:0] == gts_pkg::OFF_C_CNT) begin
        cnt_q[2] <= merge16(cnt_q[2], pwdata[15:0], pstrb[1:0]);
      end else if (wide) begin
        if (tick[1]) begin
          cnt_q[2] <= match32 ? 16'h0000 : c_next;
        end
      end else if (tick[2]) begin
        cnt_q[2] <= match16[2] ? 16'h0000 : cnt_q[2] + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Flags, interrupt requests and ADC trigger.
  // ****************************************************************
  assign ev[0] = (tick[0] && match16[0]) || gate_fall[0];
  assign ev[1] = !wide && ((tick[1] && match16[1]) || gate_fall[1]);
  assign ev[2] = wide ? ((tick[1] && match32) || gate_fall[1])
                      : ((tick[2] && match16[2]) || gate_fall[2]);

  // Writing one clears a flag; a same-cycle event wins.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= gts_pkg::IRQ_RESET;
    end else if (clk_en) begin
      if (wr && paddr[7:0] == gts_pkg::OFF_IRQ_FLAG && pstrb[0]) begin
        flag_q <= (flag_q & ~pwdata[2:0]) | ev;
      end else begin
        flag_q <= flag_q | ev;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= gts_pkg::IRQ_RESET;
      adc_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= flag_q & ien_q;
      adc_q <= wide && tick[1] && match32;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_a_irq = irq_q[0];
  assign timer_b_irq = irq_q[1];
  assign timer_c_irq = irq_q[2];
  assign adc_trigger = adc_q;
  assign time_base_b = cnt_q[1];
  assign time_base_c = cnt_q[2];

  // ****************************************************************
  // Checks.
  // ****************************************************************
  logic no_wr;
  assign no_wr = !wr;

  a_ctrl_rsv_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ctrl_q[0] & ~gts_pkg::MASK_A_CTRL) == 16'h0000)
    else $error("timer A control reserved bit set");

  a_off_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !cfg[0].count_run_enable && no_wr |=> $stable(cnt_q[0]))
    else $error("timer A counted while off");

  a_idle_halts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && idle_mode && cfg[0].idle_halt_select && no_wr
    |=> $stable(cnt_q[0]))
    else $error("timer A counted in idle with halt set");

  a_prescale_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick[0] && cfg[0].prescale_select == 2'b01 && no_wr
    |=> !tick[0] [*7])
    else $error("divide by 8 ticked too soon");

  a_gate_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !cfg[0].clock_source_select && cfg[0].gate_accumulate_enable
    && !gate_lvl[0] && no_wr |=> $stable(cnt_q[0]))
    else $error("timer A counted with gate low");

  a_wrap_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tick[0] && match16[0] && no_wr
    |=> cnt_q[0] == 16'h0000 && flag_q[0] ##1 timer_a_irq == ien_q[0])
    else $error("timer A period match mishandled");

  a_wide_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wide && tick[1] && match32 && no_wr
    |=> flag_q[2] && cnt_q[1] == 16'h0000 && cnt_q[2] == 16'h0000)
    else $error("32-bit match did not flag timer C");

  a_adc_wide: assert property (@(posedge sys_clk) disable iff (!rst_n)
    adc_trigger |-> $past(wide) && !$past(adc_trigger))
    else $error("ADC trigger outside 32-bit mode");

  a_b_quiet_wide: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && wide && !gate_fall[1] && !(wr && paddr[7:0] ==
    gts_pkg::OFF_IRQ_FLAG) && !flag_q[1] |=> !flag_q[1])
    else $error("timer B flag set in 32-bit mode");

  a_apb_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && setup |=> pready && pslverr == !$past(hit))
    else $error("APB access phase not answered");

endmodule

// ==== tb/gts_timer_set_bench.sv ====
// Self-checking bench of the general timer set, driven over APB.
// Assumes the package and the timer set are compiled before this file.
`timescale 1ns/10ps
module gts_timer_set_bench;
  logic sys_clk, rst_n, idle_mode, sleep, pin_a, pin_b, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic pready, pslverr, err, irq_a, irq_b, irq_c, adc_trig, seen, early;
  logic [15:0] tb_b, tb_c, per;
  logic [15:0] msk [3];
  int error_cnt, n_compared, n, k;

  // ****************************************************************
  // Clock and device under test.
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  gts_timer_set i_gts_timer_set (.sys_clk(sys_clk), .rst_n(rst_n),
    .clk_en(1'b1), .idle_mode(idle_mode), .sleep_mode(sleep),
    .timer_a_ext_clock_pin(pin_a), .timer_b_ext_clock_pin(pin_b),
    .timer_c_ext_clock_pin(1'b0), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h3),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_a_irq(irq_a), .timer_b_irq(irq_b), .timer_c_irq(irq_c),
    .adc_trigger(adc_trig), .time_base_b(tb_b), .time_base_c(tb_c));

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic int div_of(input int ps);
    return (ps == 3) ? 256 : (ps == 2) ? 64 : (ps == 1) ? 8 : 1;
  endfunction

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic near(input string nm, input int e, input logic [31:0] g,
                      input int tol);
    n_compared++;
    if ($isunknown(g) || int'(g) > e + tol || int'(g) + tol < e) begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int c;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (pready !== 1'b1 && c < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("BAD pready expected 1 seen %b", pready);
      end_of_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task automatic wait_hi(input int lim, output int c);
    c = 0;
    while (irq_a !== 1'b1 && c < lim) begin
      @(posedge sys_clk);
      c++;
    end
    if (irq_a !== 1'b1) begin
      error_cnt++;
      $display("BAD wait expected 1 seen %b", irq_a);
      end_of_test();
    end
  endtask

  task automatic pulses(input bit on_b, input int cnt);
    repeat (cnt) begin
      if (on_b) begin
        pin_b <= 1'b1;
      end else begin
        pin_a <= 1'b1;
      end
      repeat (3) @(posedge sys_clk);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask

  // ****************************************************************
  // Watchdog.
  // ****************************************************************
  initial begin
    repeat (90000) @(posedge sys_clk);
    error_cnt++;
    $display("BAD run_length expected end seen limit");
    end_of_test();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {rst_n, idle_mode, sleep, pin_a, pin_b, psel, penable, pwrite} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    error_cnt = 0;
    n_compared = 0;
    rnd = 32'd39734;
    msk = '{gts_pkg::MASK_A_CTRL, gts_pkg::MASK_B_CTRL, gts_pkg::MASK_C_CTRL};
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc("a_ctrl reset", gts_pkg::OFF_A_CTRL, 32'h0000_0000);
    rdc("a_per reset", gts_pkg::OFF_A_PER, 32'h0000_FFFF);
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk("unmapped err", 32'h1, {31'h0, err});
    for (int i = 0; i < 3; i++) begin
      wr(8'(i * 12), 16'hFFFF);
      rdc("ctrl mask", 8'(i * 12), {16'h0000, msk[i]});
      wr(8'(i * 12), 16'h0000);
    end
    $display("test registers done");
    wr(gts_pkg::OFF_IRQ_EN, 16'h0007);
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      per = 16'(rnd % 16) + 16'h0003;
      wr(gts_pkg::OFF_A_CNT, 16'h0000);
      wr(gts_pkg::OFF_A_PER, per);
      wr(gts_pkg::OFF_A_CTRL, 16'h8000);
      wait_hi(40, n);
      near("match time", int'(per) + 1, 32'(n), 3);
      wr(gts_pkg::OFF_A_CTRL, 16'h0000);
      rdc("a flag", gts_pkg::OFF_IRQ_FLAG, 32'h0000_0001);
      wr(gts_pkg::OFF_IRQ_FLAG, 16'h0007);
      @(posedge sys_clk);
      chk("a irq cleared", 32'h0, {31'h0, irq_a});
    end
    $display("test period match done");
    wr(gts_pkg::OFF_A_PER, 16'hFFFF);
    for (int p = 0; p < 4; p++) begin
      wr(gts_pkg::OFF_A_CNT, 16'h0000);
      wr(gts_pkg::OFF_A_CTRL, 16'h8000 | 16'(p << 4));
      repeat (512) @(posedge sys_clk);
      wr(gts_pkg::OFF_A_CTRL, 16'h0000);
      apb(1'b0, gts_pkg::OFF_A_CNT, 32'h0000_0000);
      near("prescale", 512 / div_of(p), rd, 3);
    end
    $display("test prescale done");
    for (int h = 0; h < 2; h++) begin
      wr(gts_pkg::OFF_A_CNT, 16'h0000);
      idle_mode <= 1'b1;
      wr(gts_pkg::OFF_A_CTRL, (h == 1) ? 16'hA000 : 16'h8000);
      repeat (30) @(posedge sys_clk);
      wr(gts_pkg::OFF_A_CTRL, 16'h0000);
      idle_mode <= 1'b0;
      apb(1'b0, gts_pkg::OFF_A_CNT, 32'h0000_0000);
      near("idle", (h == 1) ? 0 : 33, rd, (h == 1) ? 0 : 3);
    end
    $display("test idle done");
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      k = 3 + int'(rnd % 8);
      wr(8'((i / 2) * 12 + 4), 16'h0000);
      wr(8'((i / 2) * 12), (i == 1) ? 16'h8046 : 16'h8042);
      sleep <= (i == 0);
      pulses(i == 2, k);
      sleep <= 1'b0;
      wr(8'((i / 2) * 12), 16'h0000);
      rdc("ext count", 8'((i / 2) * 12 + 4), 32'(k));
    end
    chk("b time base", 32'(k), {16'h0000, tb_b});
    $display("test external clock done");
    wr(gts_pkg::OFF_IRQ_FLAG, 16'h0007);
    wr(gts_pkg::OFF_A_CNT, 16'h0000);
    wr(gts_pkg::OFF_A_CTRL, 16'h8040);
    repeat (20) @(posedge sys_clk);
    pulses(1'b0, 0);
    pin_a <= 1'b1;
    repeat (16) @(posedge sys_clk);
    pin_a <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr(gts_pkg::OFF_A_CTRL, 16'h0000);
    apb(1'b0, gts_pkg::OFF_A_CNT, 32'h0000_0000);
    near("gated count", 16, rd, 2);
    rdc("gate fall flag", gts_pkg::OFF_IRQ_FLAG, 32'h0000_0001);
    $display("test gate done");
    wr(gts_pkg::OFF_IRQ_FLAG, 16'h0007);
    wr(gts_pkg::OFF_B_CTRL, 16'h0008);
    wr(gts_pkg::OFF_C_CTRL, 16'h0030);
    wr(gts_pkg::OFF_B_CNT, 16'h0000);
    wr(gts_pkg::OFF_C_CNT, 16'h0000);
    wr(gts_pkg::OFF_B_PER, 16'h0002);
    wr(gts_pkg::OFF_C_PER, 16'h0001);
    idle_mode <= 1'b1;
    wr(gts_pkg::OFF_B_CTRL, 16'h8008);
    early = 1'b0;
    repeat (10) begin
      @(posedge sys_clk);
      if (adc_trig !== 1'b0) early = 1'b1;
    end
    chk("no low half match", 32'h0, {31'h0, early});
    wr(gts_pkg::OFF_B_CNT, 16'hFFFE);
    seen = 1'b0;
    n = 0;
    while (adc_trig !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
      if (tb_c === 16'h0001 && tb_b === 16'h0000) seen = 1'b1;
    end
    chk("adc trigger", 32'h1, {31'h0, adc_trig});
    chk("carry to high", 32'h1, {31'h0, seen});
    wr(gts_pkg::OFF_B_CTRL, 16'h0000);
    idle_mode <= 1'b0;
    rdc("pair flag", gts_pkg::OFF_IRQ_FLAG, 32'h0000_0004);
    chk("c irq", 32'h1, {31'h0, irq_c});
    $display("test pair done");
    wr(gts_pkg::OFF_IRQ_FLAG, 16'h0007);
    wr(gts_pkg::OFF_B_CNT, 16'h0000);
    wr(gts_pkg::OFF_B_PER, 16'h0003);
    wr(gts_pkg::OFF_B_CTRL, 16'h8000);
    early = 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      if (adc_trig !== 1'b0) early = 1'b1;
    end
    chk("b irq", 32'h1, {31'h0, irq_b});
    chk("no adc single", 32'h0, {31'h0, early});
    wr(gts_pkg::OFF_B_CTRL, 16'h0000);
    $display("test single b done");
    end_of_test();
  end
endmodule
